//--- rtl/htsr_top.v
`include "htsr_regs.vh"

module htsr_top #(
  parameter RESET_CYC = `HTSR_RESET_CYC,
  parameter BIT_CYC = `HTSR_BIT_CYC,
  parameter MEAS_CYC = `HTSR_MEAS_CYC,
  parameter FIFO_DEPTH = 16
) (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_read_request_n,
  input wire [9:0] i_temp_deci_c,
  input wire [7:0] i_humidity_pct,
  input wire i_ext_present,
  input wire [15:0] i_ext_temp_word,
  output reg o_data,
  output reg o_powered_down,
  output reg o_meas_busy
);
  // ****************************************
  // States
  // ****************************************
  localparam S_RST = 5'b00001;
  localparam S_MEAS = 5'b00010;
  localparam S_LOAD = 5'b00100;
  localparam S_SEND = 5'b01000;
  localparam S_DOWN = 5'b10000;

  // ****************************************
  // Limits
  // ****************************************
  localparam [31:0] RST_LAST = RESET_CYC - 1;
  localparam [31:0] MEAS_LAST = MEAS_CYC - 1;
  localparam [15:0] BIT_LAST = BIT_CYC[15:0] - 16'd1;
  localparam [2:0] LAST_IDX = 3'd5;
  localparam [2:0] ALL_SENT = 3'd6;
  localparam MEAS_W = 35;
  localparam [2:0] CRC_IDX = 3'd5;

  // ****************************************
  // Registers
  // ****************************************
  reg [4:0] state_q;
  reg [31:0] cnt_q;
  reg req_m_q;
  reg req_q;
  reg req_prev_q;
  reg after_q;
  reg [15:0] temp_q;
  reg [7:0] hum_q;
  reg [15:0] ext_q;
  reg [2:0] ld_idx_q;
  reg [7:0] crc_q;
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  reg [15:0] bcnt_q;
  reg sh_valid_q;
  reg [2:0] sent_q;
  reg [7:0] ld_byte;
  reg [7:0] crc_byte;
  integer k;

  // ****************************************
  // Wires
  // ****************************************
  wire req_low;
  wire flush;
  wire ld_ready;
  wire out_valid;
  wire [7:0] out_data;
  wire take;
  wire [MEAS_W-1:0] meas_raw;
  wire [MEAS_W-1:0] meas_sync;
  wire [9:0] temp_s;
  wire [7:0] hum_s;
  wire ext_pres_s;
  wire [15:0] ext_word_s;
  genvar g;

  // ****************************************
  // Request synchroniser
  // ****************************************
  // Idle high reset value avoids a false rise after reset
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      req_m_q <= 1'b1;
      req_q <= 1'b1;
      req_prev_q <= 1'b1;
    end else begin
      req_m_q <= i_read_request_n;
      req_q <= req_m_q;
      req_prev_q <= req_q;
    end
  end
  assign req_low = ~req_q;
  assign flush = req_q & ~req_prev_q;

  // ****************************************
  // Measurement input synchroniser
  // ****************************************
  // Read only at the end of a measurement, long after a change has settled
  assign meas_raw = {i_temp_deci_c, i_humidity_pct, i_ext_present, i_ext_temp_word};
  generate
    for (g = 0; g < MEAS_W; g = g + 1) begin : g_meas_sync
      reg m_q;
      reg s_q;
      always @(posedge i_ref_clk) begin
        if (i_srst) begin
          m_q <= 1'b0;
          s_q <= 1'b0;
        end else begin
          m_q <= meas_raw[g];
          s_q <= m_q;
        end
      end
      assign meas_sync[g] = s_q;
    end
  endgenerate
  assign temp_s = meas_sync[34:25];
  assign hum_s = meas_sync[24:17];
  assign ext_pres_s = meas_sync[16];
  assign ext_word_s = meas_sync[15:0];

  // ****************************************
  // Frame byte select
  // ****************************************
  // Frame byte order
  always @* begin
    case (ld_idx_q)
      3'd0: ld_byte = temp_q[15:8];
      3'd1: ld_byte = temp_q[7:0];
      3'd2: ld_byte = hum_q;
      3'd3: ld_byte = ext_q[15:8];
      3'd4: ld_byte = ext_q[7:0];
      default: ld_byte = crc_q;
    endcase
  end

  // Bitwise CRC step over a byte
  always @* begin
    crc_byte = crc_q;
    for (k = 7; k >= 0; k = k - 1) begin
      if (ld_byte[k] == crc_byte[7]) begin
        crc_byte = {crc_byte[6:0], 1'b0};
      end else begin
        crc_byte = {crc_byte[6:0], 1'b0} ^ `HTSR_CRC_TOGGLE;
        crc_byte[0] = 1'b1;
      end
    end
  end

  // ****************************************
  // Control
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= S_RST;
      cnt_q <= 32'd0;
      after_q <= 1'b0;
      temp_q <= 16'h0000;
      hum_q <= 8'h00;
      ext_q <= 16'h0000;
      ld_idx_q <= 3'd0;
      crc_q <= `HTSR_CRC_INIT;
      o_powered_down <= 1'b0;
      o_meas_busy <= 1'b0;
    end else begin
      case (state_q)
        S_RST: begin
          if (cnt_q >= RST_LAST) begin
            cnt_q <= 32'd0;
            state_q <= S_MEAS;
            o_meas_busy <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 32'd1;
          end
        end
        S_MEAS: begin
          if (cnt_q >= MEAS_LAST) begin
            cnt_q <= 32'd0;
            o_meas_busy <= 1'b0;
            temp_q <= {6'd0, temp_s} + `HTSR_TEMP_OFFSET;
            hum_q <= hum_s;
            ext_q <= ext_pres_s ? ext_word_s : {`HTSR_EXT_NONE, `HTSR_EXT_NONE};
            if (req_low & ~after_q) begin
              state_q <= S_LOAD;
              ld_idx_q <= 3'd0;
              crc_q <= `HTSR_CRC_INIT;
            end else begin
              // Power down after the extra measurement, or when no read is requested
              state_q <= S_DOWN;
              o_powered_down <= 1'b1;
              after_q <= 1'b0;
            end
          end else begin
            cnt_q <= cnt_q + 32'd1;
          end
        end
        S_DOWN: begin
          if (req_low) begin
            o_powered_down <= 1'b0;
            state_q <= S_LOAD;
            ld_idx_q <= 3'd0;
            crc_q <= `HTSR_CRC_INIT;
          end
        end
        S_LOAD: begin
          if (req_q) begin
            state_q <= S_MEAS;
            o_meas_busy <= 1'b1;
            after_q <= 1'b1;
          end else if (ld_ready) begin
            if (ld_idx_q < CRC_IDX) begin
              crc_q <= crc_byte;
            end
            if (ld_idx_q == LAST_IDX) begin
              state_q <= S_SEND;
            end else begin
              ld_idx_q <= ld_idx_q + 3'd1;
            end
          end
        end
        S_SEND: begin
          if (req_q) begin
            state_q <= S_MEAS;
            o_meas_busy <= 1'b1;
            after_q <= 1'b1;
          end
        end
        default: begin
          state_q <= S_RST;
          cnt_q <= 32'd0;
        end
      endcase
    end
  end

  // ****************************************
  // Frame FIFO
  // ****************************************
  htsr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_flush(flush),
    .i_in_valid(state_q == S_LOAD && req_low),
    .o_in_ready(ld_ready),
    .i_in_data(ld_byte),
    .o_out_valid(out_valid),
    .i_out_ready(take),
    .o_out_data(out_data)
  );

  assign take = ~sh_valid_q & req_low & (sent_q != ALL_SENT);

  // ****************************************
  // Frame byte count
  // ****************************************
  // Stops the shifter after the CRC byte until the next request
  always @(posedge i_ref_clk) begin
    if (i_srst | flush) begin
      sent_q <= 3'd0;
    end else if (take & out_valid) begin
      sent_q <= sent_q + 3'd1;
    end
  end

  // ****************************************
  // Serialiser
  // ****************************************
  always @(posedge i_ref_clk) begin
    if (i_srst | flush) begin
      sh_valid_q <= 1'b0;
      sh_q <= 8'h00;
      bit_q <= 3'd0;
      bcnt_q <= 16'd0;
      o_data <= 1'b0;
    end else if (req_q) begin
      o_data <= 1'b0;
      sh_valid_q <= 1'b0;
    end else if (take & out_valid) begin
      sh_q <= out_data;
      sh_valid_q <= 1'b1;
      bit_q <= 3'd7;
      bcnt_q <= 16'd0;
      o_data <= out_data[7];
    end else if (sh_valid_q) begin
      if (bcnt_q == BIT_LAST) begin
        bcnt_q <= 16'd0;
        if (bit_q == 3'd0) begin
          sh_valid_q <= 1'b0;
          o_data <= 1'b0;
        end else begin
          bit_q <= bit_q - 3'd1;
          o_data <= sh_q[bit_q - 3'd1];
        end
      end else begin
        bcnt_q <= bcnt_q + 16'd1;
      end
    end
  end
endmodule

//--- rtl/htsr_regs.vh
`ifndef HTSR_REGS_VH
`define HTSR_REGS_VH

// ****************************************
// Timing
// ****************************************
`define HTSR_CLK_HZ 20000000
`define HTSR_RESET_MS 20
`define HTSR_RESET_CYC ((`HTSR_CLK_HZ / 1000) * `HTSR_RESET_MS)
`define HTSR_BIT_CYC 16
`define HTSR_MEAS_CYC 64

// ****************************************
// Frame
// ****************************************
`define HTSR_FRAME_BYTES 6
`define HTSR_TEMP_OFFSET 16'h0190
`define HTSR_EXT_NONE 8'hff
`define HTSR_CRC_INIT 8'h00
`define HTSR_CRC_TOGGLE 8'h30

`endif

//--- rtl/htsr_fifo.v
// ****************************************
// Frame byte FIFO
// ****************************************
module htsr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst | i_flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- verif/htsr_top_assertions.sv
// ********
// Checker
// ********
module htsr_chk #(
  parameter RESET_CYC = 20
) (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_read_request_n,
  input wire [9:0] i_temp_deci_c,
  input wire [7:0] i_humidity_pct,
  input wire i_ext_present,
  input wire [15:0] i_ext_temp_word,
  input wire o_data,
  input wire o_powered_down,
  input wire o_meas_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [31:0] cnt_q;
  always @(posedge i_ref_clk) begin
    if (i_srst) cnt_q <= 32'h0000_0000;
    else if (cnt_q != 32'hffff_ffff) cnt_q <= cnt_q + 32'h0000_0001;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  AST_RESET_DELAY: assert property (
    cnt_q < RESET_CYC |-> !o_meas_busy && !o_data) else $error("activity in reset delay");
  AST_AUTO_MEAS: assert property (
    cnt_q == RESET_CYC |-> ##[0:4] o_meas_busy) else $error("no measurement after reset");
  AST_DATA_PD: assert property (
    o_powered_down |-> !o_data) else $error("data high in power-down");
  AST_REQ_STOP: assert property (
    i_read_request_n [*4] |-> !o_data) else $error("data not stopped");
  AST_WAKE: assert property (
    $fell(i_read_request_n) && o_powered_down |-> ##[1:5] !o_powered_down)
    else $error("no wake on request");
  AST_EXTRA_MEAS: assert property (
    $rose(i_read_request_n) && !o_powered_down |-> ##[1:5] o_meas_busy)
    else $error("no extra measurement");
  AST_MEAS_LEN: assert property (
    $rose(o_meas_busy) |-> o_meas_busy [*8] ##1 !o_meas_busy) else $error("bad meas length");
  AST_PD_AFTER_MEAS: assert property (
    $fell(o_meas_busy) && i_read_request_n |-> ##[0:2] o_powered_down)
    else $error("no power-down after measurement");
endmodule
bind htsr_top htsr_chk #(.RESET_CYC(RESET_CYC)) u_chk (.i_ref_clk(i_ref_clk),
  .i_srst(i_srst), .i_read_request_n(i_read_request_n), .i_temp_deci_c(i_temp_deci_c),
  .i_humidity_pct(i_humidity_pct), .i_ext_present(i_ext_present),
  .i_ext_temp_word(i_ext_temp_word), .o_data(o_data), .o_powered_down(o_powered_down),
  .o_meas_busy(o_meas_busy));

//--- verif/htsr_host.sv
// ********
// Host reader
// ********
module htsr_host #(
  parameter BIT_CYC = 4
) (
  input wire i_ref_clk,
  input wire i_data,
  output logic o_read_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_read_request_n = 1'b1;
  task automatic read_frame(input int nbits, output logic [47:0] f);
    int t;
    int p;
    f = 48'h0;
    t = 0;
    @(negedge i_ref_clk) o_read_request_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      p = 7 + (k / 8) * (8 * BIT_CYC + 1) + (k % 8) * BIT_CYC;
      repeat (p - t) @(negedge i_ref_clk);
      t = p;
      f[47 - k] = i_data;
    end
    @(negedge i_ref_clk) o_read_request_n = 1'b1;
  endtask
endmodule

//--- verif/htsr_top_tb.sv
// ********
// Testbench
// ********
module htsr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] temp = 10'h0c8;
  logic [7:0] hum = 8'h32;
  logic pres = 1'b0;
  logic [15:0] ext = 16'h0000;
  wire req_n;
  wire data;
  wire pd;
  wire busy;
  int mismatches = 0;
  int n_tests = 0;
  int seed;
  int s_t, s_h, s_e, n, ones;
  bit s_p;
  logic [47:0] got;
  always #25 clk = ~clk;
  htsr_top #(.RESET_CYC(20), .BIT_CYC(4), .MEAS_CYC(8), .FIFO_DEPTH(16)) uut (
    .i_ref_clk(clk), .i_srst(srst), .i_read_request_n(req_n), .i_temp_deci_c(temp),
    .i_humidity_pct(hum), .i_ext_present(pres), .i_ext_temp_word(ext),
    .o_data(data), .o_powered_down(pd), .o_meas_busy(busy));
  htsr_host #(.BIT_CYC(4)) host (.i_ref_clk(clk), .i_data(data), .o_read_request_n(req_n));
  function automatic logic [7:0] crc8(input logic [39:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 39; k >= 0; k--) begin
      if (d[k] == c[7]) c = {c[6:0], 1'b0};
      else c = {c[6:0], 1'b1} ^ 8'h30;
    end
    return c;
  endfunction
  function automatic logic [47:0] exp_frame();
    logic [39:0] d;
    d[39:24] = 16'(s_t) + 16'h0190;
    d[23:16] = 8'(s_h);
    d[15:0] = s_p ? 16'(s_e) : 16'hffff;
    return {d, crc8(d)};
  endfunction
  task automatic check(input logic [47:0] g, input logic [47:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_pd();
    int k;
    k = 0;
    while (!(pd === 1'b1 && busy === 1'b0) && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k >= 300) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pd, 1'b1);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    seed = 32'h7e47e340;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    wait_pd();
    {s_t, s_h, s_p, s_e} = {32'(temp), 32'(hum), pres, 32'(ext)};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      temp = 10'({$random(seed)} % 1101);
      hum = 8'({$random(seed)} % 101);
      pres = 1'($random(seed));
      ext = 16'($random(seed));
      n = (i == 3) ? 12 : 48;
      host.read_frame(n, got);
      check(got >> (48 - n), exp_frame() >> (48 - n));
      if (n == 48) check(48'(crc8(got[47:8])), 48'(got[7:0]));
      wait_pd();
      if (n == 48 && crc8(got[47:8]) !== got[7:0]) begin
        srst = 1'b1;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        wait_pd();
      end
      {s_t, s_h, s_p, s_e} = {32'(temp), 32'(hum), pres, 32'(ext)};
    end
    @(negedge clk);
    srst = 1'b1;
    host.o_read_request_n = 1'b0;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    ones = 0;
    repeat (300) begin
      @(negedge clk);
      if (data === 1'b1) ones++;
    end
    check(48'(ones > 0), 48'h1);
    host.o_read_request_n = 1'b1;
    wait_pd();
    report_and_stop();
  end
endmodule
